/* File: wiper_pkg.sv */
// Constants and types for the up/down wiper port controller
package wiper_pkg;
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned POS_W            = 7;
  localparam logic [6:0]  POS_MAX          = 7'h63;
  localparam logic [6:0]  POS_MIN          = 7'h00;
  localparam int unsigned POWERUP_MS       = 50;
  localparam int unsigned STORE_MS         = 10;
  localparam int unsigned T_CI_NS          = 50;
  localparam int unsigned T_DI_NS          = 100;
  localparam int unsigned T_IL_NS          = 50;
  localparam int unsigned T_IH_NS          = 100;
  localparam int unsigned T_IC_NS          = 500;
  localparam int unsigned T_CPH_NS         = 100;
  localparam int unsigned T_IK_NS          = 50;
  localparam int unsigned POWERUP_CYC      = POWERUP_MS * 1000 * CLK_MHZ;
  localparam int unsigned STORE_CYC        = STORE_MS * 1000 * CLK_MHZ;
  localparam int unsigned CI_CYC  = (T_CI_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DI_CYC  = (T_DI_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned IL_CYC  = (T_IL_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned IH_CYC  = (T_IH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned IC_CYC  = (T_IC_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CPH_CYC = (T_CPH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned IK_CYC  = (T_IK_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TMR_W            = 32;

  typedef enum logic [3:0] {
    ST_POWERUP = 4'h0,
    ST_IDLE    = 4'h1,
    ST_SELECT  = 4'h2,
    ST_DIR     = 4'h3,
    ST_LOW     = 4'h4,
    ST_HIGH    = 4'h5,
    ST_REL_LOW = 4'h6,
    ST_REL_HI  = 4'h7,
    ST_STORE   = 4'h8,
    ST_DESEL   = 4'h9,
    ST_LOCKED  = 4'ha
  } state_t;
endpackage : wiper_pkg

/* File: port_if.sv */
// Pin bundle between the sequencer and the pin driver
`timescale 1ns/10ps
`default_nettype none
interface port_if;
  logic sel_n;
  logic step_n;
  logic dir_up;
  modport src (output sel_n, output step_n, output dir_up);
  modport dst (input sel_n, input step_n, input dir_up);
endinterface : port_if
`default_nettype wire

/* File: pin_drive.sv */
// Registered pin drivers for the three control pins
`timescale 1ns/10ps
`default_nettype none
module pin_drive (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rstn,
  // Requested levels
  port_if.dst       pins,
  // Device pins
  output var  logic o_sel_n,
  output var  logic o_step_n,
  output var  logic o_dir_up
);
  // Idle levels: deselected, strobe high
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sel_n  <= 1'b1;
      o_step_n <= 1'b1;
      o_dir_up <= 1'b1;
    end else begin
      o_sel_n  <= pins.sel_n;
      o_step_n <= pins.step_n;
      o_dir_up <= pins.dir_up;
    end
  end
endmodule : pin_drive
`default_nettype wire

/* File: wiper_ctrl.sv */
// Controller that drives the up/down wiper port of an NV potentiometer
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Select pin is active low
// - Port usable only 50 ms after power-up
// - One-time use: store, then hold select high
// - Program a known position, no factory trust
// - Release with strobe low skips store
module wiper_ctrl
  import wiper_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES = POWERUP_CYC,
  parameter int unsigned STORE_CYCLES   = STORE_CYC
) (
  // Clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_rstn,
  // Command
  input  wire logic             i_cmd_valid,
  input  wire logic             i_cmd_up,
  input  wire logic [6:0]       i_cmd_steps,
  input  wire logic             i_cmd_store,
  input  wire logic             i_cmd_lock,
  output logic                  o_cmd_ready,
  output var  logic             o_done,
  output var  logic             o_locked,
  output var  logic [POS_W-1:0] o_steps_sent,
  // Device pins
  output var  logic             o_sel_n,
  output var  logic             o_step_n,
  output var  logic             o_dir_up
);
  // A zero wait would collapse the power-up and store timing
  if (POWERUP_CYCLES < 1 || STORE_CYCLES < 1) begin : g_bad_cycles
    $error("wiper_ctrl: cycle counts must be at least one");
  end

  port_if pins ();

  state_t           state;
  state_t           next_state;
  logic [TMR_W-1:0] timer;
  logic [TMR_W-1:0] next_timer;
  logic [6:0]       remaining;
  logic             up;
  logic             store;
  logic             lock;
  logic             tmr_done;

  assign tmr_done    = (timer == '0);
  assign o_cmd_ready = (state == ST_IDLE) && tmr_done;

  always_comb begin
    next_state = state;
    next_timer = tmr_done ? '0 : timer - 1'b1;
    case (state)
      ST_POWERUP: begin
        // Device reload and port wake-up both fit in this wait
        if (tmr_done) next_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (o_cmd_ready && i_cmd_valid) begin
          if (i_cmd_steps == 7'h00 && !(i_cmd_store || i_cmd_lock)) begin
            // Nothing to move or store: select and strobe stay idle; dir_up still follows the command
            next_state = ST_DESEL;
            next_timer = TMR_W'(CPH_CYC);
          end else begin
            next_state = ST_SELECT;
            next_timer = TMR_W'(CI_CYC > DI_CYC ? CI_CYC : DI_CYC);
          end
        end
      end
      ST_SELECT: begin
        if (tmr_done) begin
          // Zero steps get here only with a store pending
          next_state = (remaining == 7'h00) ? ST_REL_HI : ST_DIR;
          next_timer = (remaining == 7'h00) ? TMR_W'(IC_CYC) : '0;
        end
      end
      ST_DIR: begin
        next_state = ST_LOW;
        next_timer = TMR_W'(IL_CYC);
      end
      ST_LOW: begin
        if (tmr_done) begin
          if (remaining == 7'h01 && !store) begin
            // Last pulse stays low into the release; a fresh fall would step
            next_state = ST_REL_LOW;
            next_timer = TMR_W'(IK_CYC);
          end else begin
            next_state = ST_HIGH;
            next_timer = TMR_W'(IH_CYC);
          end
        end
      end
      ST_HIGH: begin
        if (tmr_done) begin
          if (remaining != 7'h00) begin
            next_state = ST_LOW;
            next_timer = TMR_W'(IL_CYC);
          end else begin
            // Only a storing command ends its pulses high
            next_state = ST_REL_HI;
            next_timer = TMR_W'(IC_CYC);
          end
        end
      end
      ST_REL_HI: begin
        if (tmr_done) begin
          next_state = ST_STORE;
          next_timer = TMR_W'(STORE_CYCLES);
        end
      end
      ST_REL_LOW: begin
        if (tmr_done) begin
          next_state = ST_DESEL;
          next_timer = TMR_W'(CPH_CYC);
        end
      end
      ST_STORE: begin
        // Wait out worst-case write before touching the port
        if (tmr_done) begin
          next_state = lock ? ST_LOCKED : ST_IDLE;
          next_timer = TMR_W'(CPH_CYC);
        end
      end
      ST_DESEL: begin
        if (tmr_done) next_state = ST_IDLE;
      end
      ST_LOCKED: next_state = ST_LOCKED;
      default:   next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ST_POWERUP;
      timer <= TMR_W'(POWERUP_CYCLES);
    end else begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  // Command capture and step count
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      remaining    <= 7'h00;
      up           <= 1'b1;
      store        <= 1'b0;
      lock         <= 1'b0;
      o_steps_sent <= '0;
    end else if (state == ST_IDLE && o_cmd_ready && i_cmd_valid) begin
      remaining    <= i_cmd_steps;
      up           <= i_cmd_up;
      store        <= i_cmd_store | i_cmd_lock;
      lock         <= i_cmd_lock;
      o_steps_sent <= '0;
    end else if (state == ST_LOW && tmr_done) begin
      remaining    <= remaining - 7'h01;
      o_steps_sent <= o_steps_sent + 7'h01;
    end
  end

  // Done pulse and lock flag
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_done   <= 1'b0;
      o_locked <= 1'b0;
    end else begin
      o_done   <= (state == ST_POWERUP && tmr_done) ||
                  ((state == ST_STORE || state == ST_DESEL) &&
                   tmr_done);
      o_locked <= o_locked | (next_state == ST_LOCKED);
    end
  end

  // Pin levels per state
  always_comb begin
    pins.sel_n  = 1'b0;
    pins.step_n = 1'b1;
    pins.dir_up = up;
    case (state)
      ST_POWERUP, ST_IDLE, ST_STORE, ST_DESEL, ST_LOCKED: begin
        pins.sel_n = 1'b1;
      end
      ST_LOW: pins.step_n = 1'b0;
      ST_REL_LOW: begin
        // Strobe stays low across the select release
        pins.step_n = 1'b0;
        pins.sel_n  = tmr_done;
      end
      ST_REL_HI: pins.sel_n = tmr_done;
      default: begin
        pins.sel_n = 1'b0;
      end
    endcase
  end

  pin_drive u_pin_drive (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .pins      (pins),
    .o_sel_n   (o_sel_n),
    .o_step_n  (o_step_n),
    .o_dir_up  (o_dir_up)
  );
endmodule : wiper_ctrl
`default_nettype wire

/* File: wiper_ctrl_monitor.sv */
// Checker on the wiper controller pins
`timescale 1ns/10ps
`default_nettype none
module wiper_ctrl_monitor
  import wiper_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES = POWERUP_CYC
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // Command
  input wire logic i_cmd_valid,
  input wire logic i_cmd_store,
  input wire logic i_cmd_lock,
  input wire logic o_cmd_ready,
  input wire logic o_locked,
  // Pins
  input wire logic o_sel_n,
  input wire logic o_step_n
);
  logic [31:0] cnt;
  logic        st;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) cnt <= '0;
    else if (cnt < POWERUP_CYCLES) cnt <= cnt + 32'h1;
  end
  // Store wish of the command in flight
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) st <= 1'b0;
    else if (i_cmd_valid && o_cmd_ready) st <= i_cmd_store | i_cmd_lock;
  end
  chk_step_with_sel: assert property (
    $fell(o_step_n) |-> !o_sel_n) else $error("strobe without select");
  chk_no_early_port: assert property (
    (cnt < POWERUP_CYCLES) |-> o_sel_n) else $error("port used early");
  chk_store_match: assert property (
    $rose(o_sel_n) |-> o_step_n == st) else $error("wrong release kind");
  chk_skip_hold: assert property (
    $rose(o_sel_n) && !o_step_n |-> $past(o_step_n, 4) == 1'b0)
    else $error("strobe low too short");
  chk_lock_desel: assert property (
    o_locked |-> o_sel_n) else $error("select after lock");
  chk_lock_busy: assert property (
    o_locked |-> !o_cmd_ready) else $error("ready after lock");
  cover property ($rose(o_sel_n) && o_step_n);
  cover property ($rose(o_sel_n) && !o_step_n);
  cover property ($rose(o_locked));
endmodule : wiper_ctrl_monitor
bind wiper_ctrl wiper_ctrl_monitor #(.POWERUP_CYCLES(POWERUP_CYCLES)) u_mon (
  .i_clk_sys, .i_rstn, .i_cmd_valid, .i_cmd_store, .i_cmd_lock,
  .o_cmd_ready, .o_locked, .o_sel_n, .o_step_n);
`default_nettype wire

/* File: pot_model.sv */
// Behavioural up/down potentiometer on the three port pins
`timescale 1ns/10ps
`default_nettype none
module pot_model (
  // Supply, high while powered
  input  wire logic       i_pwr,
  // Port pins
  input  wire logic       i_sel_n,
  input  wire logic       i_step_n,
  input  wire logic       i_dir_up,
  // Observed state
  output var  logic [6:0] o_pos,
  output var  logic [6:0] o_nv,
  output var  int         o_writes
);
  // Shipped content is arbitrary
  initial o_nv = 7'h2a;
  initial o_writes = 0;
  // Lost value shows as an unused code
  always @(negedge i_pwr) o_pos = 7'h7f;
  always @(posedge i_pwr) o_pos = o_nv;
  always @(negedge i_step_n) begin
    if (i_pwr && !i_sel_n) begin
      if (i_dir_up && o_pos < 7'h63) o_pos = o_pos + 7'h01;
      else if (!i_dir_up && o_pos > 7'h00) o_pos = o_pos - 7'h01;
    end
  end
  always @(posedge i_sel_n) begin
    if (i_pwr && i_step_n) begin
      o_nv = o_pos;
      o_writes = o_writes + 1;
    end
  end
endmodule : pot_model
`default_nettype wire

/* File: wiper_ctrl_test.sv */
// Self-checking bench for the wiper port controller
`timescale 1ns/10ps
`default_nettype none
module wiper_ctrl_test;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       vld = 1'b0;
  logic       up = 1'b0;
  logic [6:0] n = 7'h00;
  logic       st = 1'b0;
  logic       lk = 1'b0;
  logic       rdy, done, lkd, sel_n, step_n, dir;
  logic [6:0] sent, pos, nv;
  int         wr, fail_count, n_compared;
  always #5 clk = ~clk;
  wiper_ctrl #(.POWERUP_CYCLES(20), .STORE_CYCLES(20)) u_wiper_ctrl (
    .i_clk_sys(clk), .i_rstn(rstn), .i_cmd_valid(vld), .i_cmd_up(up),
    .i_cmd_steps(n), .i_cmd_store(st), .i_cmd_lock(lk), .o_cmd_ready(rdy),
    .o_done(done), .o_locked(lkd), .o_steps_sent(sent), .o_sel_n(sel_n),
    .o_step_n(step_n), .o_dir_up(dir));
  pot_model u_pot_model (.i_pwr(rstn), .i_sel_n(sel_n), .i_step_n(step_n),
    .i_dir_up(dir), .o_pos(pos), .o_nv(nv), .o_writes(wr));
  task automatic chk(input string s, input logic [6:0] e, input logic [6:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task automatic cmd(input logic u, c, input logic [6:0] k, input logic l);
    int t;
    t = 0;
    @(negedge clk);
    while (rdy !== 1'b1 && t < 300) begin
      @(negedge clk);
      t++;
    end
    vld = 1'b1;
    up = u;
    st = c;
    n = k;
    lk = l;
    @(negedge clk);
    vld = 1'b0;
    t = 0;
    while (done !== 1'b1 && t < 4000) begin
      @(posedge clk);
      #1;
      t++;
    end
    chk("done", 7'h01, {6'h00, done});
    chk("steps_sent", k, sent);
  endtask : cmd
  task automatic t_program;
    cmd(1'b0, 1'b1, 7'h7f, 1'b0);
    chk("pos", 7'h00, pos);
    chk("nv", 7'h00, nv);
  endtask : t_program
  task automatic t_step;
    cmd(1'b1, 1'b1, 7'h05, 1'b0);
    chk("pos", 7'h05, pos);
    cmd(1'b0, 1'b0, 7'h02, 1'b0);
    chk("pos", 7'h03, pos);
    chk("nv", 7'h05, nv);
    chk("writes", 7'h02, wr[6:0]);
    cmd(1'b1, 1'b0, 7'h00, 1'b0);
    chk("pos", 7'h03, pos);
    chk("writes", 7'h02, wr[6:0]);
    cmd(1'b1, 1'b1, 7'h00, 1'b0);
    chk("nv", 7'h03, nv);
    chk("pos", 7'h03, pos);
  endtask : t_step
  task automatic t_reload;
    cmd(1'b1, 1'b1, 7'h7f, 1'b0);
    chk("pos", 7'h63, pos);
    cmd(1'b0, 1'b0, 7'h03, 1'b0);
    chk("pos", 7'h60, pos);
    @(negedge clk);
    rstn = 1'b0;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    // Power-up wait ends with a done pulse
    @(posedge done);
    chk("pos", 7'h63, pos);
    chk("writes", 7'h04, wr[6:0]);
  endtask : t_reload
  task automatic t_lock;
    cmd(1'b0, 1'b0, 7'h01, 1'b1);
    chk("nv", 7'h62, nv);
    @(negedge clk);
    vld = 1'b1;
    repeat (40) @(negedge clk);
    chk("locked", 7'h01, {6'h00, lkd});
    chk("ready", 7'h00, {6'h00, rdy});
    chk("pos", 7'h62, pos);
    vld = 1'b0;
  endtask : t_lock
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    t_program();
    t_step();
    t_reload();
    t_lock();
    end_sim();
  end
  // Whole run is near 5100 cycles
  initial begin
    #200000;
    fail_count++;
    end_sim();
  end
endmodule : wiper_ctrl_test
`default_nettype wire
